// file: src/ccp_output_shaping.sv
// Output shaping for a capture/compare/PWM module: pin gating, one-shot
// stretch, mode steering, polarity, shutdown states and dead time.
// Assumes the time base supplies pwm_level, period_start and count_tick.
module ccp_output_shaping
  import ccp_pkg::*;
#(
  parameter bit MULTI_OUTPUT = 1'b1
)
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    triggered_operation_enable,
  input  wire logic                    trigger_state,
  input  wire logic                    shutdown_event,
  input  wire logic                    period_start,
  input  wire logic                    count_tick,
  input  wire logic                    one_shot_event,
  input  wire logic                    pwm_level,
  input  wire logic [CCP_NUM_PINS-1:0] pin_enable,
  output ccp_pins_type                 pwm_pins,
  output logic                         one_shot_active
);

  localparam logic [31:0] WMASK = MULTI_OUTPUT ? CCP_WMASK_MULTI : CCP_WMASK_SINGLE;

  ccp_state_type           q;
  ccp_state_type           d;
  ccp_ctl_type             c;
  logic                    hold;
  logic                    req;
  logic                    dt_on;
  logic [31:0]             rsel;
  logic [31:0]             bmask;
  logic [CCP_NUM_PINS-1:0] intent;
  logic [CCP_NUM_PINS-1:0] lvl;
  logic [1:0]              pss;
  logic                    pol;

  // Assertions further down share the block clock and hold off while reset is low.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  assign c = q.ctl;

  // Outputs come straight from the state register.
  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = q.wreq;
  assign pwm_pins        = q.pins;
  assign one_shot_active = q.os_act;

  // Next-state logic for the whole block.
  always_comb
  begin
    d      = q;
    hold   = triggered_operation_enable && c.output_wait_for_trigger && !trigger_state;
    req    = avs_read || avs_write;
    bmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    intent = '0;
    lvl    = '0;
    pss    = 2'h0;
    pol    = 1'b0;

    // Read multiplexer; the stored control word already has its gaps zeroed.
    unique case (avs_address)
      CCP_CTL_OFFSET:  rsel = c & WMASK;
      CCP_STAT_OFFSET:
      begin
        rsel = 32'h0000_0000;
        rsel[CCP_ST_TRIG] = trigger_state;
        rsel[CCP_ST_SD]   = shutdown_event;
        rsel[CCP_ST_OS]   = q.os_act;
        rsel[CCP_ST_HOLD] = hold;
      end
      default:         rsel = 32'h0000_0000;
    endcase

    // Every access waits exactly one cycle; the write lands on the answer edge.
    d.wreq = 1'b1;
    if (q.wreq && req)
    begin
      d.wreq  = 1'b0;
      d.rdata = avs_read ? rsel : 32'h0000_0000;
    end
    if (!q.wreq && avs_write && avs_address == CCP_CTL_OFFSET)
    begin
      d.ctl = ccp_ctl_type'((c & ~(WMASK & bmask))
                            | (avs_writedata & WMASK & bmask));
    end

    // A new one-shot event restarts the stretch; each count period uses one step.
    if (one_shot_event)
    begin
      d.os_act = 1'b1;
      d.os_cnt = c.one_shot_extend_count;
    end
    else if (q.os_act && count_tick)
    begin
      if (q.os_cnt == 3'h0)
      begin
        d.os_act = 1'b0;
      end
      else
      begin
        d.os_cnt = q.os_cnt - 3'h1;
      end
    end

    // Push-pull alternates and scan rotates once per PWM period.
    if (period_start)
    begin
      d.phase    = !q.phase;
      d.scan_idx = (q.scan_idx == CCP_SCAN_LAST) ? 3'h0 : q.scan_idx + 3'h1;
    end

    // Steering of the raw PWM level onto the six pins.
    unique case (c.output_mode_select)
      CCP_MODE_SINGLE:    intent = {CCP_NUM_PINS{pwm_level}};
      CCP_MODE_PUSH_PULL:
      begin
        intent[0] = pwm_level && !q.phase;
        intent[1] = pwm_level && q.phase;
      end
      CCP_MODE_HALF:
      begin
        intent[0] = pwm_level;
        intent[1] = !pwm_level;
      end
      CCP_MODE_BDC_FWD:
      begin
        intent[0] = 1'b1;
        intent[3] = pwm_level;
      end
      CCP_MODE_BDC_REV:
      begin
        intent[2] = 1'b1;
        intent[1] = pwm_level;
      end
      CCP_MODE_SCAN:      intent[q.scan_idx] = pwm_level;
      default:            intent = '0;
    endcase

    // Dead time only matters where two pins are complementary.
    dt_on = (c.dead_time_periods != 6'h00) && (c.output_mode_select == CCP_MODE_HALF);

    for (int i = 0; i < CCP_NUM_PINS; i++)
    begin
      // A rising intent is delayed by the dead-time count, falling is immediate.
      if (!intent[i])
      begin
        d.dt_cnt[i] = c.dead_time_periods;
        lvl[i]      = 1'b0;
      end
      else if (dt_on && q.dt_cnt[i] != 6'h00)
      begin
        d.dt_cnt[i] = q.dt_cnt[i] - 6'h01;
        lvl[i]      = 1'b0;
      end
      else
      begin
        lvl[i] = 1'b1;
      end

      pol = i[0] ? c.polarity_group_two : c.polarity_group_one;
      pss = i[0] ? c.shutdown_state_group_two : c.shutdown_state_group_one;

      // Hold beats shutdown: pins stay released until the trigger comes.
      if (hold || !pin_enable[i])
      begin
        d.pins.oe[i]    = 1'b0;
        d.pins.level[i] = 1'b0;
      end
      else if (shutdown_event)
      begin
        d.pins.oe[i]    = pss[1];
        d.pins.level[i] = pss[1] && (pss[0] ^ pol);
      end
      else
      begin
        d.pins.oe[i]    = 1'b1;
        d.pins.level[i] = lvl[i] ^ pol;
      end
    end
  end

  // Single state register; reset only loads constants.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q       <= '0;
      q.ctl   <= ccp_ctl_type'(CCP_CTL_RESET);
      q.wreq  <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  sequence s_hold;
    triggered_operation_enable && c.output_wait_for_trigger && !trigger_state;
  endsequence

  property p_hold;
    s_hold |=> (pwm_pins.oe == 6'h00);
  endproperty
  a_hold: assert property (p_hold) else $error("pins driven while waiting for trigger");

  property p_os_start;
    one_shot_event |=> q.os_act && (q.os_cnt == $past(c.one_shot_extend_count));
  endproperty
  a_os_start: assert property (p_os_start) else $error("one-shot did not load");

  property p_os_end;
    q.os_act && count_tick && q.os_cnt == 3'h0 && !one_shot_event |=> !one_shot_active;
  endproperty
  a_os_end: assert property (p_os_end) else $error("one-shot overran");

  sequence s_run(logic [2:0] m);
    c.output_mode_select == m && !hold && !shutdown_event && c.dead_time_periods == 6'h00;
  endsequence

  property p_half;
    s_run(3'h2) ##0 (pin_enable[1:0] == 2'h3) && (c.polarity_group_one == c.polarity_group_two)
      |=> pwm_pins.level[0] != pwm_pins.level[1];
  endproperty
  a_half: assert property (p_half) else $error("half-bridge not complementary");

  property p_pol_one;
    s_run(3'h0) ##0 pin_enable[2]
      |=> pwm_pins.level[2] == ($past(pwm_level) ^ $past(c.polarity_group_one));
  endproperty
  a_pol_one: assert property (p_pol_one) else $error("group one polarity wrong");

  property p_pol_two;
    s_run(3'h0) ##0 pin_enable[3]
      |=> pwm_pins.level[3] == ($past(pwm_level) ^ $past(c.polarity_group_two));
  endproperty
  a_pol_two: assert property (p_pol_two) else $error("group two polarity wrong");

  sequence s_sd_held;
    (shutdown_event && !hold && pin_enable[0]) [*2];
  endsequence

  property p_sd_one;
    s_sd_held ##0 c.shutdown_state_group_one == CCP_PSS_ACTIVE
      |=> pwm_pins.oe[0] && pwm_pins.level[0] == !$past(c.polarity_group_one);
  endproperty
  a_sd_one: assert property (p_sd_one) else $error("group one shutdown state wrong");

  property p_sd_float;
    shutdown_event && !c.shutdown_state_group_one[1] |=> !pwm_pins.oe[0] && !pwm_pins.oe[2];
  endproperty
  a_sd_float: assert property (p_sd_float) else $error("group one not floated");

  property p_sd_two;
    shutdown_event && !hold && pin_enable[1] && c.shutdown_state_group_two == CCP_PSS_INACTIVE
      |=> pwm_pins.oe[1] && pwm_pins.level[1] == $past(c.polarity_group_two);
  endproperty
  a_sd_two: assert property (p_sd_two) else $error("group two shutdown state wrong");

  property p_resume;
    $fell(shutdown_event) && !hold && pin_enable[4] && c.shutdown_state_group_one == 2'h0
      |=> pwm_pins.oe[4];
  endproperty
  a_resume: assert property (p_resume) else $error("drive did not resume");

  property p_rsvd;
    !avs_waitrequest |-> avs_readdata[27] == 1'b0 && avs_readdata[23:22] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("unimplemented bits read non-zero");

  property p_variant;
    MULTI_OUTPUT || (c.output_mode_select == CCP_MODE_SINGLE && !c.polarity_group_two);
  endproperty
  a_variant: assert property (p_variant) else $error("multi fields in single variant");

  // With a zero dead-time field a half-bridge pin follows its input without delay.
  property p_dead;
    s_run(3'h2) ##0 pin_enable[0] && !c.polarity_group_one
      |=> pwm_pins.level[0] == $past(pwm_level);
  endproperty
  a_dead: assert property (p_dead) else $error("zero dead time delayed a pin");

  // Scan mode drives at most one pin active at a time.
  property p_scan;
    s_run(3'h6) ##0 (pin_enable == 6'h3f) && !c.polarity_group_one && !c.polarity_group_two
      |=> $onehot0(pwm_pins.level);
  endproperty
  a_scan: assert property (p_scan) else $error("scan drove several pins");

  property p_dt;
    c.output_mode_select == CCP_MODE_HALF && c.dead_time_periods >= 6'h02 && !hold
      && !shutdown_event && pin_enable[0] && !c.polarity_group_one && $rose(pwm_level)
      |=> !pwm_pins.level[0] ##1 !pwm_pins.level[0];
  endproperty
  a_dt: assert property (p_dt) else $error("dead time not inserted");

endmodule

// file: src/ccp_pkg.sv
// Constants and carrier types for the output-shaping block of a PWM module.
// Assumes one 100 MHz clock and a 32-bit word-addressed Avalon-MM slave port.
// Function
// - Trigger mode with hold bit set keeps enabled pins undriven until triggered.
// - One-shot extend value n stretches each one-shot event to n+1 count periods.
// - Mode field picks single, push-pull, half-bridge, brush DC reverse/forward, scan.
// - Group one polarity bit set makes pins A, C, E active-low.
// - Group two polarity bit set makes pins B, D, F active-low.
// - During shutdown group one drives active on 11, inactive on 10, floats on 0x.
// - Control bits 27 and 23 to 22 always read as zero.
// - Mode field and group two polarity exist only in the multi-output variant.
// - During shutdown group two drives active on 11, inactive on 10, floats on 0x.
// - Dead-time value n inserts n delay periods; zero disables dead time; the code applies it in half-bridge mode only.
package ccp_pkg;

  localparam int          CCP_NUM_PINS   = 6;
  localparam logic [3:0]  CCP_CTL_OFFSET = 4'h0;
  localparam logic [3:0]  CCP_STAT_OFFSET = 4'h4;
  localparam logic [31:0] CCP_CTL_RESET  = 32'h0000_0000;
  // Writable bits per variant; everything else reads as zero.
  localparam logic [31:0] CCP_WMASK_MULTI  = 32'hf73f_003f;
  localparam logic [31:0] CCP_WMASK_SINGLE = 32'hf02c_0000;
  localparam logic [1:0]  CCP_PSS_ACTIVE   = 2'h3;
  localparam logic [1:0]  CCP_PSS_INACTIVE = 2'h2;
  localparam logic [2:0]  CCP_SCAN_LAST    = 3'h5;
  // Status register bit positions.
  localparam int CCP_ST_TRIG = 0;
  localparam int CCP_ST_SD   = 1;
  localparam int CCP_ST_OS   = 2;
  localparam int CCP_ST_HOLD = 3;

  typedef enum logic [2:0] {
    CCP_MODE_SINGLE    = 3'h0,
    CCP_MODE_PUSH_PULL = 3'h1,
    CCP_MODE_HALF      = 3'h2,
    CCP_MODE_RSVD3     = 3'h3,
    CCP_MODE_BDC_REV   = 3'h4,
    CCP_MODE_BDC_FWD   = 3'h5,
    CCP_MODE_SCAN      = 3'h6,
    CCP_MODE_RSVD7     = 3'h7
  } ccp_mode_type;

  // Layout of pwm_output_control_three, bit 31 first.
  typedef struct packed {
    logic         output_wait_for_trigger;
    logic [2:0]   one_shot_extend_count;
    logic         rsvd27;
    ccp_mode_type output_mode_select;
    logic [1:0]   rsvd23;
    logic         polarity_group_one;
    logic         polarity_group_two;
    logic [1:0]   shutdown_state_group_one;
    logic [1:0]   shutdown_state_group_two;
    logic [9:0]   rsvd15;
    logic [5:0]   dead_time_periods;
  } ccp_ctl_type;

  typedef struct packed {
    logic [CCP_NUM_PINS-1:0] level;
    logic [CCP_NUM_PINS-1:0] oe;
  } ccp_pins_type;

  typedef struct packed {
    ccp_ctl_type                   ctl;
    logic                          wreq;
    logic [31:0]                   rdata;
    logic                          os_act;
    logic [2:0]                    os_cnt;
    logic                          phase;
    logic [2:0]                    scan_idx;
    logic [CCP_NUM_PINS-1:0][5:0]  dt_cnt;
    ccp_pins_type                  pins;
  } ccp_state_type;

endpackage

// file: testbench/ccp_power_stage.sv
// Behavioural far-side power stage that watches the six PWM pins.
// Assumes the pin bundle of the output-shaping block and the module clock.
module ccp_power_stage
  import ccp_pkg::*;
(
  input  wire logic                    clk,
  input  wire ccp_pins_type            pins,
  output logic      [CCP_NUM_PINS-1:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [CCP_NUM_PINS-1:0] last_q = '0;

  // A floating pin has no pull, so it shows the inverse of its last level.
  always_comb
  begin
    for (int i = 0; i < CCP_NUM_PINS; i++)
      seen[i] = pins.oe[i] ? pins.level[i] : ~last_q[i];
  end

  // Remember the wire level so a float toggles every cycle.
  always_ff @(posedge clk)
  begin
    last_q <= seen;
  end
endmodule

// file: testbench/test_ccp_output_shaping.sv
// Self-checking bench for the output-shaping block over its register bus.
// Assumes one 100 MHz clock and the power stage model on the pins.
module test_ccp_output_shaping
  import ccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [3:0]   addr = 4'h0;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic [31:0]  wdata = 32'h0;
  logic [31:0]  rdata;
  logic         wait_req;
  logic         trig_en = 1'b0;
  logic         trig_st = 1'b0;
  logic         sd = 1'b0;
  logic         ps = 1'b0;
  logic         tick = 1'b0;
  logic         os_ev = 1'b0;
  logic         pwm = 1'b0;
  logic [5:0]   pen = 6'h00;
  ccp_pins_type pins;
  logic         os_act;
  logic [5:0]   seen;
  int           errors = 0;
  int           n_checks = 0;
  logic [5:0]   mode_exp [8] = '{6'h3f, 6'h01, 6'h01, 6'h00, 6'h06, 6'h09, 6'h01, 6'h00};

  ccp_output_shaping ccp_output_shaping_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .triggered_operation_enable(trig_en),
    .trigger_state(trig_st), .shutdown_event(sd), .period_start(ps), .count_tick(tick),
    .one_shot_event(os_ev), .pwm_level(pwm), .pin_enable(pen), .pwm_pins(pins),
    .one_shot_active(os_act));

  ccp_power_stage ccp_power_stage_inst (.clk(clk), .pins(pins), .seen(seen));

  // Free-running clock, 10 ns period.
  always #5 clk = ~clk;

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: pins %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access; the request stays up until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    // Only the watchdog ends a wait that never gets an answer.
    do
    begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk_reg(q, exp);
  endtask

  // Waits n cycles, then compares pin levels and enables once settled.
  task automatic pin_chk(input int n, input logic [5:0] lvl, input logic [5:0] oe);
    repeat (n) @(posedge clk);
    #1;
    chk_pin(pins.level, lvl);
    chk_pin(pins.oe, oe);
  endtask

  // Fires one one-shot event and counts n+1 ticks before it must end.
  task automatic os_run(input int n);
    wr_reg(4'h0, {1'b0, n[2:0], 28'h0});
    @(posedge clk);
    os_ev <= 1'b1;
    @(posedge clk);
    os_ev <= 1'b0;
    for (int i = 0; i <= n; i++)
    begin
      @(posedge clk);
      tick <= 1'b1;
      #1;
      chk_reg({31'h0, os_act}, 32'h1);
      @(posedge clk);
      tick <= 1'b0;
    end
    @(posedge clk);
    #1;
    chk_reg({31'h0, os_act}, 32'h0);
  endtask

  // Main sequence of register and pin scenarios.
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(4'h0, 32'h0);
    wr_reg(4'h0, 32'hffff_ffff);
    rd_chk(4'h0, 32'hf73f_003f);
    rd_chk(4'h8, 32'h0);
    pen <= 6'h3f;
    pwm <= 1'b1;
    for (int m = 0; m < 8; m++)
    begin
      wr_reg(4'h0, {5'h0, m[2:0], 24'h0});
      repeat (2) @(posedge clk);
      #1;
      chk_pin(pins.level, mode_exp[m]);
    end
    wr_reg(4'h0, 32'h0100_0000);
    @(posedge clk);
    ps <= 1'b1;
    @(posedge clk);
    ps <= 1'b0;
    pin_chk(2, 6'h02, 6'h3f);
    wr_reg(4'h0, 32'h0600_0000);
    pin_chk(2, 6'h02, 6'h3f);
    wr_reg(4'h0, 32'h0020_0000);
    pin_chk(2, 6'h2a, 6'h3f);
    wr_reg(4'h0, 32'h0010_0000);
    pin_chk(2, 6'h15, 6'h3f);
    wr_reg(4'h0, 32'h000e_0000);
    sd <= 1'b1;
    pwm <= 1'b0;
    pin_chk(3, 6'h15, 6'h3f);
    chk_pin(seen, 6'h15);
    wr_reg(4'h0, 32'h0000_0000);
    pin_chk(2, 6'h00, 6'h00);
    rd_chk(4'h4, 32'h2);
    sd <= 1'b0;
    pwm <= 1'b1;
    pin_chk(2, 6'h3f, 6'h3f);
    wr_reg(4'h0, 32'h8000_0000);
    trig_en <= 1'b1;
    pin_chk(2, 6'h00, 6'h00);
    @(posedge clk);
    trig_st <= 1'b1;
    pin_chk(2, 6'h3f, 6'h3f);
    wr_reg(4'h0, 32'h0200_0003);
    pwm <= 1'b0;
    repeat (3) @(posedge clk);
    pwm <= 1'b1;
    pin_chk(2, 6'h00, 6'h3f);
    pin_chk(1, 6'h00, 6'h3f);
    pin_chk(1, 6'h01, 6'h3f);
    os_run(0);
    os_run(1);
    os_run(7);
    final_report();
  end

  // Cuts a hang short well beyond the length of the scenarios.
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule
